// *** hdl/csc_regs_map.vh ***
`ifndef CSC_REGS_MAP_VH
`define CSC_REGS_MAP_VH

// group base address, offsets are relative to it
`define CSC_BASE_ADDR        32'he000ed00
`define CSC_OFS_IDENTITY     12'h000
`define CSC_OFS_ICS          12'h004
`define CSC_OFS_IRC          12'h00c
`define CSC_OFS_SYSCTL       12'h010
`define CSC_OFS_PRIO_TWO     12'h01c
`define CSC_OFS_PRIO_THREE   12'h020
`define CSC_OFS_EVT_STATUS   12'h040
`define CSC_OFS_EVT_MASK     12'h044

// identity fields
`define CSC_ID_IMPL_MSB      31
`define CSC_ID_IMPL_LSB      24
`define CSC_ID_ARCH_MSB      19
`define CSC_ID_ARCH_LSB      16
`define CSC_ID_PART_MSB      15
`define CSC_ID_PART_LSB      4
`define CSC_ID_REV_MSB       3
`define CSC_ID_REV_LSB       0

// interrupt control and state bits
`define CSC_ICS_NMI_PEND     31
`define CSC_ICS_DC_SET       28
`define CSC_ICS_DC_CLR       27
`define CSC_ICS_TICK_SET     26
`define CSC_ICS_TICK_CLR     25

// reset values
`define CSC_RST_ICS          32'h00000000
`define CSC_RST_IRC          32'hfa050000
`define CSC_RST_SYSCTL       32'h00000000
`define CSC_RST_PRIO         32'h00000000
`define CSC_RST_ARCH         4'h0
`define CSC_RST_REV          4'h0

// event status bits
`define CSC_EVT_NMI          0
`define CSC_EVT_DC           1
`define CSC_EVT_TICK         2
`define CSC_EVT_W            3

`endif

// *** hdl/csc_pend_bit.v ***
`timescale 1ns/1ps

// one pending flag: set beats clear in the same cycle
module csc_pend_bit (
	input  wire pclk,     // bus clock
	input  wire presetn,  // async reset, active low
	input  wire set_i,    // set request
	input  wire clr_i,    // clear request
	output reg  pend_r    // pending state
);

////////////////////////////////////////////////////////////////////////////////
// set wins so no event is lost against a concurrent clear
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		pend_r <= 1'b0;
	else if (set_i)
		pend_r <= 1'b1;
	else if (clr_i)
		pend_r <= 1'b0;
end

endmodule // csc_pend_bit

// *** hdl/csc_sysctl.v ***
`timescale 1ns/1ps
`include "csc_regs_map.vh"

module csc_sysctl #(
	parameter [7:0]  IMPL_CODE = 8'h5a,   // arbitrary value
	parameter [11:0] PART_CODE = 12'h123, // arbitrary value
	parameter [31:0] BASE      = `CSC_BASE_ADDR
) (
	input  wire        pclk,          // bus clock, 10 MHz
	input  wire        presetn,       // async reset, active low
	input  wire        psel,          // apb select
	input  wire        penable,       // apb access phase
	input  wire        pwrite,        // apb write
	input  wire [31:0] paddr,         // apb byte address
	input  wire [31:0] pwdata,        // apb write data
	input  wire [3:0]  pstrb,         // apb byte strobes
	output wire        pready,        // apb ready, always high
	output reg  [31:0] prdata,        // apb read data
	output wire        pslverr,       // apb error on unmapped address
	input  wire        nmi_req,       // nonmaskable request pulse
	input  wire        nmi_enter,     // core enters nonmaskable handler
	input  wire        dc_enter,      // core enters deferred call handler
	input  wire        tick_req,      // tick exception request pulse
	input  wire        tick_enter,    // core enters tick handler
	output wire        nmi_pending,   // nonmaskable pending level
	output wire        dc_pending,    // deferred call pending level
	output wire        tick_pending,  // tick pending level
	output wire [31:0] irc_value,     // interrupt/reset control contents
	output wire [31:0] sysctl_value,  // system control contents
	output wire [31:0] prio_two,      // handler priority two contents
	output wire [31:0] prio_three,    // handler priority three contents
	output wire        irq            // level interrupt, unmasked events
);

////////////////////////////////////////////////////////////////////////////////
// storage
reg  [3:0]             arch_r;
reg  [3:0]             rev_r;
reg  [31:0]            irc_r;
reg  [31:0]            sysctl_r;
reg  [31:0]            prio2_r;
reg  [31:0]            prio3_r;
reg  [`CSC_EVT_W-1:0]  evt_r;
reg  [`CSC_EVT_W-1:0]  mask_r;
reg  [`CSC_EVT_W-1:0]  evt_nxt;
reg  [31:0]            rd_nxt;
reg                    hit;

wire [11:0] ofs;
wire        in_range;
wire        wr_en;
wire        rd_en;
wire        ics_wr;
wire [31:0] ics_read;
wire [31:0] id_read;

// byte-lane merge used by the irc, sysctl and both priority registers
function [31:0] merge;
	input [31:0] old;
	input [31:0] din;
	input [3:0]  strb;
	integer      i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1)
			if (strb[i])
				merge[i*8 +: 8] = din[i*8 +: 8];
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// address decode; zero-wait slave
assign ofs      = paddr[11:0] - BASE[11:0];
assign in_range = (paddr[31:12] == BASE[31:12]) && (paddr[11:0] >= BASE[11:0]);
assign pready   = 1'b1;
assign wr_en    = psel && penable && pwrite && hit;
assign rd_en    = psel && !penable && !pwrite;
assign pslverr  = psel && penable && !hit;
assign ics_wr   = wr_en && (ofs == `CSC_OFS_ICS) && pstrb[3];

// command bits all sit in the top byte, so byte 3 must be strobed
wire w_nmi    = ics_wr && pwdata[`CSC_ICS_NMI_PEND];
wire w_dc_set = ics_wr && pwdata[`CSC_ICS_DC_SET];
wire w_dc_clr = ics_wr && pwdata[`CSC_ICS_DC_CLR];
wire w_tk_set = ics_wr && pwdata[`CSC_ICS_TICK_SET];
wire w_tk_clr = ics_wr && pwdata[`CSC_ICS_TICK_CLR];

////////////////////////////////////////////////////////////////////////////////
// pending flags; a nmi_req or tick_req reassertion during the handler sets it again
csc_pend_bit u_nmi (
	.pclk    (pclk),
	.presetn (presetn),
	.set_i   (w_nmi | nmi_req),
	.clr_i   (nmi_enter),
	.pend_r  (nmi_pending)
);

csc_pend_bit u_dc (
	.pclk    (pclk),
	.presetn (presetn),
	.set_i   (w_dc_set),
	.clr_i   (w_dc_clr | dc_enter),
	.pend_r  (dc_pending)
);

csc_pend_bit u_tick (
	.pclk    (pclk),
	.presetn (presetn),
	.set_i   (w_tk_set | tick_req),
	.clr_i   (w_tk_clr | tick_enter),
	.pend_r  (tick_pending)
);

////////////////////////////////////////////////////////////////////////////////
// read views; write-only and reserved bits read zero
// pad is 26 bits so tick pending lands on bit 26 and the word is a full 32
assign ics_read = {nmi_pending, 2'b00, dc_pending, 1'b0, tick_pending, 26'h0000000};
assign id_read  = {IMPL_CODE, 4'h0, arch_r, PART_CODE, rev_r};

assign irc_value    = irc_r;
assign sysctl_value = sysctl_r;
assign prio_two     = prio2_r;
assign prio_three   = prio3_r;

////////////////////////////////////////////////////////////////////////////////
// read mux and decode hit
always @* begin
	hit    = in_range;
	rd_nxt = 32'h00000000;
	case (ofs)
		`CSC_OFS_IDENTITY:   rd_nxt = id_read;
		`CSC_OFS_ICS:        rd_nxt = ics_read;
		`CSC_OFS_IRC:        rd_nxt = irc_r;
		`CSC_OFS_SYSCTL:     rd_nxt = sysctl_r;
		`CSC_OFS_PRIO_TWO:   rd_nxt = prio2_r;
		`CSC_OFS_PRIO_THREE: rd_nxt = prio3_r;
		`CSC_OFS_EVT_STATUS: rd_nxt = {29'h0, evt_r};
		`CSC_OFS_EVT_MASK:   rd_nxt = {29'h0, mask_r};
		default:             hit = 1'b0;
	endcase
	if (!in_range)
		rd_nxt = 32'h00000000;
end

// read data registered in setup, valid during access
always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		prdata <= 32'h00000000;
	else if (rd_en)
		prdata <= rd_nxt;
end

////////////////////////////////////////////////////////////////////////////////
// plain read/write registers
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		arch_r   <= `CSC_RST_ARCH;
		rev_r    <= `CSC_RST_REV;
		irc_r    <= `CSC_RST_IRC;
		sysctl_r <= `CSC_RST_SYSCTL;
		prio2_r  <= `CSC_RST_PRIO;
		prio3_r  <= `CSC_RST_PRIO;
		mask_r   <= {`CSC_EVT_W{1'b0}};
	end else if (wr_en) begin
		case (ofs)
			`CSC_OFS_IDENTITY: begin
				// only architecture and revision are writable
				if (pstrb[2])
					arch_r <= pwdata[`CSC_ID_ARCH_MSB:`CSC_ID_ARCH_LSB];
				if (pstrb[0])
					rev_r <= pwdata[`CSC_ID_REV_MSB:`CSC_ID_REV_LSB];
			end
			`CSC_OFS_IRC:        irc_r <= merge(irc_r, pwdata, pstrb);
			`CSC_OFS_SYSCTL:     sysctl_r <= merge(sysctl_r, pwdata, pstrb);
			`CSC_OFS_PRIO_TWO:   prio2_r <= merge(prio2_r, pwdata, pstrb);
			`CSC_OFS_PRIO_THREE: prio3_r <= merge(prio3_r, pwdata, pstrb);
			`CSC_OFS_EVT_MASK: begin
				if (pstrb[0])
					mask_r <= pwdata[`CSC_EVT_W-1:0];
			end
			default: ;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////////////
// sticky event status, write one to clear; new events beat the clear
always @* begin
	evt_nxt = evt_r;
	if (wr_en && (ofs == `CSC_OFS_EVT_STATUS) && pstrb[0])
		evt_nxt = evt_nxt & ~pwdata[`CSC_EVT_W-1:0];
	if (nmi_req | w_nmi)
		evt_nxt[`CSC_EVT_NMI] = 1'b1;
	if (w_dc_set)
		evt_nxt[`CSC_EVT_DC] = 1'b1;
	if (tick_req | w_tk_set)
		evt_nxt[`CSC_EVT_TICK] = 1'b1;
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		evt_r <= {`CSC_EVT_W{1'b0}};
	else
		evt_r <= evt_nxt;
end

// level interrupt while any unmasked event is held
assign irq = |(evt_r & mask_r);

endmodule // csc_sysctl

// *** verification/csc_sysctl_monitor.sv ***
`timescale 1ns/1ps
module csc_sysctl_monitor (
	input wire        pclk,         // bus clock
	input wire        presetn,      // async reset, active low
	input wire        psel,         // apb select
	input wire        penable,      // apb access phase
	input wire        pwrite,       // apb write
	input wire [31:0] paddr,        // apb address
	input wire [31:0] pwdata,       // apb write data
	input wire [3:0]  pstrb,        // apb strobes
	input wire        pready,       // apb ready
	input wire        pslverr,      // apb error
	input wire        nmi_req,      // nonmaskable request
	input wire        nmi_enter,    // nonmaskable entry
	input wire        tick_req,     // tick request
	input wire        nmi_pending,  // nonmaskable pending
	input wire        dc_pending,   // deferred pending
	input wire        tick_pending, // tick pending
	input wire [31:0] irc_value     // control contents
);
	////////////////////////////////////////
	// completed write to the state register, command lane enabled
	wire acc = psel & penable & pready;
	wire ics = acc & pwrite & pstrb[3] & (paddr == 32'he000ed04);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_nmi_set: assert property (ics && pwdata[31] |=> nmi_pending)
		else $error("nmi set lost");
	a_nmi_hold: assert property (!nmi_pending && !nmi_req && !(ics && pwdata[31])
		|=> !nmi_pending) else $error("nmi set unprompted");
	a_nmi_entry: assert property (nmi_enter && !nmi_req && !(ics && pwdata[31])
		|=> !nmi_pending) else $error("nmi entry no clear");
	a_dc_set: assert property (ics && pwdata[28] |=> dc_pending)
		else $error("deferred set lost");
	a_dc_only: assert property (!dc_pending && !(ics && pwdata[28]) |=> !dc_pending)
		else $error("deferred set unprompted");
	a_dc_clear: assert property (ics && pwdata[27] && !pwdata[28] |=> !dc_pending)
		else $error("deferred clear lost");
	a_tick_set: assert property (ics && pwdata[26] |=> tick_pending)
		else $error("tick set lost");
	a_tick_clear: assert property (ics && pwdata[25] && !pwdata[26] && !tick_req
		|=> !tick_pending) else $error("tick clear lost");
	a_irc_reset: assert property ($rose(presetn) |-> irc_value == 32'hfa050000)
		else $error("control reset value");
	a_hole_err: assert property (acc && paddr == 32'he000ed08 |-> pslverr)
		else $error("unmapped not refused");
endmodule // csc_sysctl_monitor
bind csc_sysctl csc_sysctl_monitor csc_sysctl_monitor_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .pready(pready), .pslverr(pslverr), .nmi_req(nmi_req),
	.nmi_enter(nmi_enter), .tick_req(tick_req), .nmi_pending(nmi_pending),
	.dc_pending(dc_pending), .tick_pending(tick_pending), .irc_value(irc_value));

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, rd, mem [int];
	logic [3:0]  pstrb = 4'hf;
	logic [4:0]  ev = 0;  // nmi req, nmi entry, deferred entry, tick req, tick entry
	logic        np = 0, dp = 0, tp = 0, er;
	logic [3:0]  arch = 0, revision_field = 0;
	logic [2:0]  st = 0;
	logic [11:0] offs [4] = '{12'h00c, 12'h010, 12'h01c, 12'h020};
	wire         pready, pslverr, nmi_pending, dc_pending, tick_pending, irq;
	wire  [31:0] prdata;
	int          fail_count = 0, cmp_count = 0;
	csc_sysctl #(.IMPL_CODE(8'h3c), .PART_CODE(12'h456)) csc_sysctl_inst (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.nmi_req(ev[4]), .nmi_enter(ev[3]), .dc_enter(ev[2]), .tick_req(ev[1]),
		.tick_enter(ev[0]), .nmi_pending(nmi_pending), .dc_pending(dc_pending),
		.tick_pending(tick_pending), .irc_value(), .sysctl_value(), .prio_two(),
		.prio_three(), .irq(irq));
	initial forever #50 pclk = ~pclk;
	////////////////////////////////////////
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// master holds everything until pready is seen high
	task apb(input logic w, input logic [11:0] o, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= 32'he000ed00 + o;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// write plus model update; set beats clear
	task wr(input logic [11:0] o, input logic [31:0] d);
		apb(1, o, d);
		if (o == 12'h004) begin
			np = np | d[31];
			dp = d[28] | (dp & ~d[27]);
			tp = d[26] | (tp & ~d[25]);
		end else if (o == 12'h000) begin
			arch = d[19:16];
			revision_field = d[3:0];
		end else if (o == 12'h040) st = st & ~d[2:0];
		else mem[o] = d;
		#1;
	endtask
	task rdc(input logic [11:0] o);
		logic [31:0] e;
		case (o)
			12'h000: e = {8'h3c, 4'h0, arch, 12'h456, revision_field};
			12'h004: e = {np, 2'b00, dp, 1'b0, tp, 26'h0};
			12'h040: e = {29'h0, st};
			default: e = mem.exists(o) ? mem[o] : 32'h0;
		endcase
		apb(0, o, 32'h0);
		chk($sformatf("reg %h", o), rd, e);
	endtask
	task pulse(input int b);
		@(posedge pclk);
		ev[b] <= 1;
		@(posedge pclk);
		ev[b] <= 0;
		case (b)
			4: np = 1;
			3: np = 0;
			2: dp = 0;
			1: {tp, st[2]} = 2'b11;
			default: tp = 0;
		endcase
	endtask
	task end_sim;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		fail_count++;
		end_sim;
	end
	////////////////////////////////////////
	initial begin
		void'($urandom(32'h5d08));
		mem[12'h00c] = 32'hfa050000;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		for (int i = 0; i < 4; i++) rdc(offs[i]);
		rdc(12'h000);
		rdc(12'h004);
		wr(12'h000, 32'hffffffff);
		rdc(12'h000);
		for (int i = 0; i < 4; i++) begin
			wr(offs[i], $urandom);
			rdc(offs[i]);
		end
		wr(12'h004, 32'hf4000000);
		rdc(12'h004);
		chk("pending", {nmi_pending, dc_pending, tick_pending}, {np, dp, tp});
		wr(12'h004, 32'h0);
		rdc(12'h004);
		wr(12'h004, 32'h0a000000);
		rdc(12'h004);
		pulse(3);
		rdc(12'h004);
		pulse(4);
		rdc(12'h004);
		// events: clear stale status, then raise, mask, clear
		wr(12'h040, 32'h7);
		wr(12'h044, 32'h4);
		pulse(1);
		rdc(12'h040);
		chk("irq", irq, 1);
		wr(12'h044, 32'h0);
		chk("irq", irq, 0);
		wr(12'h044, 32'h4);
		wr(12'h040, 32'h4);
		rdc(12'h040);
		chk("irq", irq, 0);
		// hole in the map: write dropped, read refused
		apb(1, 12'h008, $urandom);
		rdc(12'h008);
		chk("slverr", er, 1);
		end_sim;
	end
endmodule // testbench
